// ### design/acd_decode.sv
/*
 * Holds the control word register of the amplifier configuration decoder and
 * turns it into switch and current-source controls.
 * Assumes the serial shifter delivers a whole word with a same-clock write strobe.
 */
// Overview of operation
// [R01] A one in the power-down bit puts the amplifier into shutdown, a zero keeps it active.
// [R02] For gain codes 0 to 6 the feedback switch follows the external filter select bit.
// [R03] Gain code 7 holds the feedback switch closed whatever the filter select bit says.
// [R04] Filter select set with a compensation code top bit of one makes the amp unity-gain stable.
// [R05] The host clears the filter select bit whenever no external filter capacitor is fitted.
// [R06] The probe current goes to the positive input for pin select zero, else the negative one.
// [R07] Current code 0 is off and unpowered, 1-5 give 10nA-100uA, 6 is off but powered, 7 barred.
// [R08] Route codes 2 and 3 float one input, divide the other by 50 and tie the spare input low.
// [R09] In divide-by-50 routing gain codes 0 to 6 give 0.2 to 20, and the sign flip negates them.
// [R10] The host writes 0x0082 or 0x00C2 for the common-mode test, each at unity overall gain.
// [R11] The host writes 0x5082 then 0x58C2 at 100uA and flags a degraded line on a mismatch.
// [R12] The host writes 0x5000 for the shorted-input test at gain code zero with 100uA.
// [R13] The gain code sits in bits 2 to 0, codes 0 to 6 fixed gains and code 7 external gain.
// [R14] Route select and sign flip sit in bits 8 to 6.
// [R15] The bandwidth compensation code sits in bits 5 to 3.
// [R16] Reset clears the whole control word to zero, and it stays zero until the supply has settled.
module acd_decode (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic word_write,
    input wire logic [15:0] word_data,
    output logic settled,
    output logic power_down,
    output logic feedback_switch_b,
    output logic gain_switch_a,
    output logic unity_gain_stable,
    output logic [2:0] gain_code,
    output logic [2:0] bandwidth_comp_code,
    output logic [1:0] input_route_select,
    output logic input_sign_flip,
    output logic divide_by_50,
    output logic tie_spare_low,
    output logic probe_to_negative,
    output logic [4:0] probe_current_sel,
    output logic probe_powered,
    output logic bad_current_code
);
    logic [15:0] amplifier_control_word;
    logic [10:0] settle_cnt;
    logic [15:0] cw;

    // Gain code 7 hands the gain to external resistors; the switches and the gain switch check share this test.
    function automatic logic is_ext_gain(input logic [2:0] code);
        return code == acd_pkg::GAIN_EXTERNAL;
    endfunction

    // One-hot select of the probe current magnitude, empty for the off and barred codes.
    function automatic logic [4:0] cur_onehot(input logic [2:0] code);
        if (code >= 3'h1 && code <= 3'h5) begin
            return 5'(5'h01 << (code - 3'h1));
        end
        return 5'h00;
    endfunction

    // Writes before the supply settles are dropped, so early glitches cannot corrupt the word.
    wire settle_done = (settle_cnt == 11'(acd_pkg::SETTLE_CYCLES));
    wire take = clk_en && settle_done && word_write;
    wire [15:0] next_word = take ? word_data : amplifier_control_word;
    assign cw = next_word;

    wire [2:0] nx_gain = cw[acd_pkg::GAIN_LSB +: 3];                    // [R13]
    wire [2:0] nx_comp = cw[acd_pkg::COMP_LSB +: 3];                    // [R15]
    wire [1:0] nx_route = cw[acd_pkg::ROUTE_LSB +: 2];                  // [R14]
    wire nx_sign = cw[acd_pkg::SIGN_BIT];                               // [R14]
    wire nx_ext_filter_select = cw[acd_pkg::EXT_FILTER_SELECT_BIT];
    wire [2:0] nx_cur = cw[acd_pkg::CUR_LSB +: 3];
    wire nx_ext = is_ext_gain(nx_gain);                                 // [R13]
    wire nx_fb = nx_ext | nx_ext_filter_select;                                      // [R02] [R03]
    wire nx_div = nx_route[1];                                          // [R08] [R09]
    wire nx_bad = (nx_cur == acd_pkg::CUR_FORBIDDEN);                   // [R07]
    wire [4:0] nx_sel = cur_onehot(nx_cur);                             // [R07]
    wire nx_pow = (nx_cur != acd_pkg::CUR_OFF_DOWN) && !nx_bad;         // [R07]

    // Fields of the stored word, read only by the checks below.
    wire [2:0] held_gain = amplifier_control_word[acd_pkg::GAIN_LSB +: 3];
    wire [2:0] held_comp = amplifier_control_word[acd_pkg::COMP_LSB +: 3];
    wire [1:0] held_route = amplifier_control_word[acd_pkg::ROUTE_LSB +: 2];
    wire held_sign = amplifier_control_word[acd_pkg::SIGN_BIT];
    wire held_pdown = amplifier_control_word[acd_pkg::PDOWN_BIT];
    wire held_ext_filter_select = amplifier_control_word[acd_pkg::EXT_FILTER_SELECT_BIT];
    wire [2:0] held_cur = amplifier_control_word[acd_pkg::CUR_LSB +: 3];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            settle_cnt <= 11'h000;
            settled <= 1'b0;
            amplifier_control_word <= acd_pkg::WORD_RESET;             // [R16]
            power_down <= 1'b0;
            feedback_switch_b <= 1'b0;
            gain_switch_a <= 1'b1;
            unity_gain_stable <= 1'b0;
            gain_code <= 3'h0;
            bandwidth_comp_code <= 3'h0;
            input_route_select <= 2'h0;
            input_sign_flip <= 1'b0;
            divide_by_50 <= 1'b0;
            tie_spare_low <= 1'b0;
            probe_to_negative <= 1'b0;
            probe_current_sel <= 5'h00;
            probe_powered <= 1'b0;
            bad_current_code <= 1'b0;
        end else if (clk_en) begin
            if (!settle_done) begin
                settle_cnt <= settle_cnt + 11'h001;
            end
            settled <= settle_done;
            amplifier_control_word <= next_word;
            power_down <= cw[acd_pkg::PDOWN_BIT];                      // [R01]
            feedback_switch_b <= nx_fb;                                // [R02] [R03]
            gain_switch_a <= !nx_ext;                                  // [R13]
            unity_gain_stable <= nx_ext_filter_select && nx_comp[2];                // [R04]
            gain_code <= nx_gain;
            bandwidth_comp_code <= nx_comp;
            input_route_select <= nx_route;
            input_sign_flip <= nx_sign;                                // [R09]
            divide_by_50 <= nx_div;                                    // [R08]
            tie_spare_low <= nx_div;                                   // [R08]
            probe_to_negative <= cw[acd_pkg::PIN_BIT];                 // [R06]
            probe_current_sel <= nx_sel;                               // [R07]
            probe_powered <= nx_pow;                                   // [R07]
            bad_current_code <= nx_bad;                                // [R07]
        end
    end

    property p_shutdown;
        @(posedge clk) disable iff (!resetn)
        (clk_en && take) |=> (power_down == $past(word_data[9]));
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("power-down mismatch"); // [R01]

    property p_fb_follow;
        @(posedge clk) disable iff (!resetn)
        (gain_code != 3'h7) |-> (feedback_switch_b == amplifier_control_word[10]);
    endproperty
    a_fb_follow: assert property (p_fb_follow) else $error("feedback switch wrong"); // [R02]

    property p_fb_ext;
        @(posedge clk) disable iff (!resetn)
        (gain_code == 3'h7) |-> (feedback_switch_b && !gain_switch_a);
    endproperty
    a_fb_ext: assert property (p_fb_ext) else $error("external gain switch wrong"); // [R03]

    property p_unity;
        @(posedge clk) disable iff (!resetn)
        unity_gain_stable |-> (amplifier_control_word[10] && bandwidth_comp_code[2]);
    endproperty
    a_unity: assert property (p_unity) else $error("unity-gain mismatch"); // [R04]

    property p_pin;
        @(posedge clk) disable iff (!resetn)
        probe_to_negative == amplifier_control_word[11];
    endproperty
    a_pin: assert property (p_pin) else $error("probe pin mismatch"); // [R06]

    property p_cur100u;
        @(posedge clk) disable iff (!resetn)
        (amplifier_control_word[14:12] == 3'h5) |-> (probe_current_sel == 5'h10 && probe_powered);
    endproperty
    a_cur100u: assert property (p_cur100u) else $error("current decode wrong"); // [R07]

    property p_curoff;
        @(posedge clk) disable iff (!resetn)
        (amplifier_control_word[14:12] == 3'h6) |-> (probe_current_sel == 5'h00 && probe_powered);
    endproperty
    a_curoff: assert property (p_curoff) else $error("powered-off decode wrong"); // [R07]

    property p_div;
        @(posedge clk) disable iff (!resetn)
        divide_by_50 == held_route[1] && tie_spare_low == held_route[1];
    endproperty
    a_div: assert property (p_div) else $error("divide routing wrong"); // [R08]

    property p_pdown_hold;
        @(posedge clk) disable iff (!resetn)
        power_down == held_pdown;
    endproperty
    a_pdown_hold: assert property (p_pdown_hold) else $error("power-down not held"); // [R01]

    property p_unity_set;
        @(posedge clk) disable iff (!resetn)
        (held_ext_filter_select && held_comp[2]) |-> unity_gain_stable;
    endproperty
    a_unity_set: assert property (p_unity_set) else $error("unity-gain not set"); // [R04]

    property p_gain_a;
        @(posedge clk) disable iff (!resetn)
        gain_switch_a == !is_ext_gain(gain_code);
    endproperty
    a_gain_a: assert property (p_gain_a) else $error("gain switch wrong"); // [R13]

    property p_gain_field;
        @(posedge clk) disable iff (!resetn)
        gain_code == held_gain;
    endproperty
    a_gain_field: assert property (p_gain_field) else $error("gain code field wrong"); // [R13]

    property p_comp_field;
        @(posedge clk) disable iff (!resetn)
        bandwidth_comp_code == held_comp;
    endproperty
    a_comp_field: assert property (p_comp_field) else $error("compensation field wrong"); // [R15]

    property p_route_field;
        @(posedge clk) disable iff (!resetn)
        input_route_select == held_route && input_sign_flip == held_sign;
    endproperty
    a_route_field: assert property (p_route_field) else $error("route field wrong"); // [R14]

    property p_cur_down;
        @(posedge clk) disable iff (!resetn)
        (held_cur == acd_pkg::CUR_OFF_DOWN) |-> (probe_current_sel == 5'h00 && !probe_powered);
    endproperty
    a_cur_down: assert property (p_cur_down) else $error("unpowered decode wrong"); // [R07]

    property p_cur_bad;
        @(posedge clk) disable iff (!resetn)
        bad_current_code == (held_cur == acd_pkg::CUR_FORBIDDEN) &&
        (!bad_current_code || (probe_current_sel == 5'h00 && !probe_powered));
    endproperty
    a_cur_bad: assert property (p_cur_bad) else $error("barred current code wrong"); // [R07]

    property p_cur_onehot;
        @(posedge clk) disable iff (!resetn)
        $onehot0(probe_current_sel);
    endproperty
    a_cur_onehot: assert property (p_cur_onehot) else $error("current select not one-hot"); // [R07]

    property p_early_drop;
        @(posedge clk) disable iff (!resetn)
        (word_write && !settle_done) |=> (amplifier_control_word == acd_pkg::WORD_RESET);
    endproperty
    a_early_drop: assert property (p_early_drop) else $error("early write taken"); // [R16]

    property p_settle_cnt;
        @(posedge clk) disable iff (!resetn)
        settle_cnt <= 11'(acd_pkg::SETTLE_CYCLES);
    endproperty
    a_settle_cnt: assert property (p_settle_cnt) else $error("settle count overran"); // [R16]

    property p_settle;
        @(posedge clk) disable iff (!resetn)
        !settled |-> (amplifier_control_word == 16'h0000);
    endproperty
    a_settle: assert property (p_settle) else $error("word not clear before settle"); // [R16]
endmodule

// ### shared/acd_pkg.sv
/*
 * Holds the control word layout, reset value and decode codes of the amplifier
 * configuration decoder.
 * Assumes a single 40 MHz clock domain and nothing else around it.
 */
package acd_pkg;
    localparam int WORD_W = 16;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam int GAIN_LSB = 0;
    localparam int COMP_LSB = 3;
    localparam int SIGN_BIT = 8;
    localparam int ROUTE_LSB = 6;
    localparam int PDOWN_BIT = 9;
    localparam int EXT_FILTER_SELECT_BIT = 10;
    localparam int PIN_BIT = 11;
    localparam int CUR_LSB = 12;
    localparam logic [2:0] GAIN_EXTERNAL = 3'h7;
    localparam logic [2:0] CUR_OFF_DOWN = 3'h0;
    localparam logic [2:0] CUR_OFF_POWERED = 3'h6;
    localparam logic [2:0] CUR_FORBIDDEN = 3'h7;
    localparam int SETTLE_NS = 50000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = 11;
endpackage

// ### testbench/acd_host_model.sv
/*
 * Host model that writes whole control words into the amplifier configuration decoder.
 * Assumes the bench calls its tasks just after a falling clock edge.
 */
module acd_host_model #(
    parameter bit CAP_FITTED = 1'b1
) (
    output logic word_write,
    output logic [15:0] word_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Common-mode, degraded-line and shorted-input test words.
    function automatic logic [15:0] test_word(input int idx);
        case (idx)
            0: return 16'h0082;
            1: return 16'h00C2;
            2: return 16'h5082;
            3: return 16'h58C2;
            default: return 16'h5000;
        endcase
    endfunction
    initial begin
        word_write = 1'b0;
        word_data = 16'h0000;
    end
    // Without a filter capacitor the filter select bit is always cleared.
    task automatic put(input logic [15:0] w);
        word_write = 1'b1;
        word_data = CAP_FITTED ? w : (w & 16'hFBFF);
    endtask
    // A released data bus shows the inverse of the last word, so stale data cannot pass.
    task automatic idle();
        word_write = 1'b0;
        word_data = ~word_data;
    endtask
endmodule

// ### testbench/test_amp_config_decode.sv
/*
 * Self-checking bench for the amplifier configuration decoder.
 * Assumes the host model drives all writes and outputs update one cycle after a write.
 */
module test_amp_config_decode;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic resetn;
    logic clk_en;
    wire logic word_write;
    wire logic [15:0] word_data;
    wire logic settled;
    wire logic [22:0] seen;
    int err_count;
    int n_checks;
    acd_host_model host (.word_write(word_write), .word_data(word_data));
    acd_decode dut (.clk(clk), .resetn(resetn), .clk_en(clk_en), .word_write(word_write),
        .word_data(word_data), .settled(settled), .power_down(seen[22]),
        .feedback_switch_b(seen[21]), .gain_switch_a(seen[20]), .unity_gain_stable(seen[19]),
        .gain_code(seen[18:16]), .bandwidth_comp_code(seen[15:13]),
        .input_route_select(seen[12:11]), .input_sign_flip(seen[10]), .divide_by_50(seen[9]),
        .tie_spare_low(seen[8]), .probe_to_negative(seen[7]), .probe_current_sel(seen[6:2]),
        .probe_powered(seen[1]), .bad_current_code(seen[0]));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Route is bits 7:6 and sign bit 8, so the test words 0x0082 and 0x00C2 pick routes 10 and 11.
    function automatic logic [22:0] expect_of(input logic [15:0] w);
        logic [2:0] c;
        c = w[14:12];
        return {w[9], (w[2:0] == 3'h7) | w[10], w[2:0] != 3'h7, w[10] & w[5], w[2:0], w[5:3],
            w[7:6], w[8], w[7], w[7], w[11], (c >= 3'h1 && c <= 3'h5) ? 5'h01 << (c - 3'h1) : 5'h00,
            c >= 3'h1 && c <= 3'h6, c == 3'h7};
    endfunction
    task automatic check(input logic [22:0] s, input logic [22:0] e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Reset, an early write that must be dropped, then a bounded wait for settling.
    task automatic do_reset();
        resetn = 1'b0;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        check(seen, expect_of(16'h0000));
        host.put(16'h5082);
        @(negedge clk);
        host.idle();
        check(seen, expect_of(16'h0000));
        for (int k = 0; k < 3000 && settled !== 1'b1; k++) @(negedge clk);
        if (settled !== 1'b1) begin
            err_count++;
            complete_run();
        end
        @(negedge clk);
    endtask
    task automatic apply(input logic [15:0] w);
        host.put(w);
        @(negedge clk);
        check(seen, expect_of(w));
    endtask
    // Back-to-back writes sweeping every field code, including gain 7 and current 7.
    task automatic sweep();
        for (int i = 0; i < 64; i++) apply({1'b0, i[2:0], i[3], i[4], i[5], i[2:0], i[5:3], i[2:0]});
        host.idle();
        @(negedge clk);
    endtask
    task automatic fault_words();
        for (int i = 0; i < 5; i++) apply(host.test_word(i));
        apply(16'h0182);
        apply(16'h5000);
        host.idle();
        @(negedge clk);
    endtask
    // A write with the clock enable low must leave the last word in place.
    task automatic freeze();
        clk_en = 1'b0;
        host.put(16'h0200);
        @(negedge clk);
        host.idle();
        clk_en = 1'b1;
        @(negedge clk);
        check(seen, expect_of(16'h5000));
    endtask
    initial begin
        resetn = 1'b0;
        clk_en = 1'b1;
        do_reset();
        sweep();
        fault_words();
        freeze();
        do_reset();
        complete_run();
    end
endmodule
